// File: rtl/mcg_map.vh
// register map, field positions, reset values and timing counts of the master clock generator
`ifndef MCG_MAP_VH
`define MCG_MAP_VH

// register byte offsets
`define MCG_CTRL_OFF        12'h000
`define MCG_STROBE_OFF      12'h004
`define MCG_STATUS_OFF      12'h008
`define MCG_EXTKHZ_OFF      12'h00C
`define MCG_TIMER_OFF       12'h010
`define MCG_WAKE_OFF        12'h014

// field positions
`define MCG_DIV_MSB         4
`define MCG_STB_FAST        0
`define MCG_STB_SLOW        1
`define MCG_ST_SRC_SLOW     0
`define MCG_ST_BUSY         1
`define MCG_ST_DET_DONE     2
`define MCG_ST_RATE_OK      3
`define MCG_ST_WAKE         4

// divisor limits and reset value
`define MCG_DIV_MIN         5'h02
`define MCG_DIV_MAX         5'h10
`define MCG_DIV_RST         5'h10

// core clock window for the fastest data rate, in kHz
`define MCG_CORE_MIN_KHZ    11000
`define MCG_CORE_MAX_KHZ    16000
`define MCG_EXTKHZ_RST      16'hABE0

// missing-edge detection length, in watch crystal periods
`define MCG_DET_PERIODS     2'h2

// rated limits, in MHz
`define MCG_CORE_RATED_MHZ  25
`define MCG_EXT_RATED_MHZ   50

`endif

// File: rtl/mcg_master_clock.v
// master clock generator: source select, glitch-free prescaler, sleep interval timer
`include "mcg_map.vh"

// usage limits:
// - each source is sampled on sys_clk, so it must stay below half the sys_clk rate
// - both edges of the selected source advance the prescaler
// - a switch waits for the core low phase on the old source; a dead old
//   source while core is high leaves the switch pending
// - strobes that arrive while a switch is pending are ignored
// - a strobe ends the missing-edge detection after reset
// - the interval timer counts watch crystal rising edges only
// - the wake flag is sticky; writing one to its status bit clears it, a
//   coincident compare hit wins

// Functional notes
// - flag core rate within 11 to 16 MHz
// - intermediate tick at twice core, halved
// - first stage counts half source periods
// - overall divisor programmable 2 to 16
// - core and companion from selected source
// - fast and slow strobes switch glitch-free
// - no external edge in two periods: slow
// - no watch crystal: detector never fires
// - reset loads divisor of 16
// - divisor change only at low phase boundary
// - watch crystal drives sleep interval timer
// - works up to 25 MHz core, 50 external
module mcg_master_clock (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // clock sources
    input  wire        external_clock_input,
    input  wire        watch_crystal_clock,
    // generated clocks and wake-up
    output reg         core_clk_q,
    output reg         companion_core_clock_q,
    output reg         wake_q
);

    // switch sequencer: run, wait for a low phase, wait for the new source
    localparam [1:0] SW_RUN  = 2'b00;
    localparam [1:0] SW_STOP = 2'b01;
    localparam [1:0] SW_GO   = 2'b10;

    reg  [1:0]  sw_state_q;
    reg         src_slow_q;
    reg         src_req_slow_q;
    reg  [4:0]  div_q;
    reg  [4:0]  div_pend_q;
    reg  [4:0]  edge_cnt_q;
    reg         gate_on_q;
    reg         hist_valid_q;
    reg         ext_prev_q;
    reg         wcc_prev_q;
    reg         det_active_q;
    reg  [1:0]  det_cnt_q;
    reg  [15:0] ext_khz_q;
    reg  [31:0] timer_q;
    reg  [31:0] wake_cmp_q;

    // level change between the sampled pin and its history
    function edge_of;
        input cur;
        input prev;
        input valid;
        begin
            edge_of = valid & (cur ^ prev);
        end
    endfunction

    // history is only trusted one cycle after reset, so no false edge follows it
    wire ext_edge = edge_of(external_clock_input, ext_prev_q, hist_valid_q);
    wire wcc_rise = hist_valid_q & watch_crystal_clock & ~wcc_prev_q;
    wire wcc_edge = edge_of(watch_crystal_clock, wcc_prev_q, hist_valid_q);
    wire src_edge = src_slow_q ? wcc_edge : ext_edge;
    wire new_edge = src_req_slow_q ? wcc_edge : ext_edge;

    wire [4:0] half_div  = {1'b0, div_q[4:1]};
    wire       last_edge = (edge_cnt_q == div_q - 5'h01);
    wire       tick      = gate_on_q & src_edge & last_edge;
    wire       low_start = tick & core_clk_q;

    // a write lands at the access edge; read data is prepared at the setup edge
    // so that it already stands when pready is sampled
    wire wr_en = psel & penable & pwrite & pready;
    wire rd_en = psel & ~penable & ~pwrite;

    // keeps a written divisor inside the legal range
    function [4:0] clamp_div;
        input [31:0] v;
        begin
            if (v < {27'h0, `MCG_DIV_MIN})
                clamp_div = `MCG_DIV_MIN;
            else if (v > {27'h0, `MCG_DIV_MAX})
                clamp_div = `MCG_DIV_MAX;
            else
                clamp_div = v[4:0];
        end
    endfunction

    // true when the external rate over the divisor lands in the fast-rate window
    function rate_in_window;
        input [15:0] khz;
        input [4:0]  d;
        reg   [31:0] lo;
        reg   [31:0] hi;
        begin
            lo = `MCG_CORE_MIN_KHZ * {27'h0, d};
            hi = `MCG_CORE_MAX_KHZ * {27'h0, d};
            rate_in_window = ({16'h0, khz} >= lo) && ({16'h0, khz} <= hi);
        end
    endfunction

    // true for the six register offsets
    function addr_mapped;
        input [11:0] a;
        begin
            case (a)
                `MCG_CTRL_OFF,
                `MCG_STROBE_OFF,
                `MCG_STATUS_OFF,
                `MCG_EXTKHZ_OFF,
                `MCG_TIMER_OFF,
                `MCG_WAKE_OFF:   addr_mapped = 1'b1;
                default:         addr_mapped = 1'b0;
            endcase
        end
    endfunction

    // read data of a mapped register, zero elsewhere
    function [31:0] read_word;
        input [11:0] a;
        input [4:0]  pend;
        input [4:0]  act;
        input [4:0]  status;
        input [15:0] khz;
        input [31:0] count;
        input [31:0] cmp;
        begin
            case (a)
                `MCG_CTRL_OFF:   read_word = {19'h0, pend, 3'h0, act};
                `MCG_STATUS_OFF: read_word = {27'h0, status};
                `MCG_EXTKHZ_OFF: read_word = {16'h0, khz};
                `MCG_TIMER_OFF:  read_word = count;
                `MCG_WAKE_OFF:   read_word = cmp;
                default:         read_word = 32'h0000_0000;
            endcase
        end
    endfunction

    wire rate_ok = ~src_slow_q & rate_in_window(ext_khz_q, div_q);
    wire busy    = (sw_state_q != SW_RUN) | det_active_q;
    wire [4:0] status_bits = {wake_q, rate_ok, ~det_active_q, busy, src_slow_q};

    wire strobe_wr  = wr_en & (paddr == `MCG_STROBE_OFF);
    wire fast_stb   = strobe_wr & pwdata[`MCG_STB_FAST];
    wire slow_stb   = strobe_wr & pwdata[`MCG_STB_SLOW] & ~pwdata[`MCG_STB_FAST];
    wire [31:0] timer_nxt = timer_q + 32'h0000_0001;
    wire wake_hit   = (timer_nxt == wake_cmp_q);
    wire wake_clear = wr_en & (paddr == `MCG_STATUS_OFF) & pwdata[`MCG_ST_WAKE];

    // input history for edge detection
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hist_valid_q <= 1'b0;
            ext_prev_q   <= 1'b0;
            wcc_prev_q   <= 1'b0;
        end else begin
            hist_valid_q <= 1'b1;
            ext_prev_q <= external_clock_input;
            wcc_prev_q <= watch_crystal_clock;
        end
    end

    // prescaler: each source edge is half a source period
    // div source edges make one core phase, so one core period is div source
    // periods; an odd div gives the half-step ratio of the first stage
    // a new divisor only takes effect where a low phase begins
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_cnt_q             <= 5'h00;
            core_clk_q             <= 1'b0;
            companion_core_clock_q <= 1'b0;
            div_q                  <= `MCG_DIV_RST;
        end else if (!gate_on_q) begin
            edge_cnt_q <= 5'h00;
        end else if (src_edge) begin
            if (last_edge) begin
                // every div half periods the intermediate clock ticks; core halves it
                edge_cnt_q <= 5'h00;
                core_clk_q <= ~core_clk_q;
                if (core_clk_q)
                    div_q <= div_pend_q;
            end else begin
                edge_cnt_q <= edge_cnt_q + 5'h01;
            end
            // companion lags by half an intermediate period
            if (edge_cnt_q == half_div - 5'h01)
                companion_core_clock_q <= core_clk_q;
        end
    end

    // source switch sequencer
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sw_state_q     <= SW_RUN;
            src_slow_q     <= 1'b0;
            src_req_slow_q <= 1'b0;
            gate_on_q      <= 1'b1;
        end else begin
            case (sw_state_q)
                SW_RUN: begin
                    if (det_active_q && wcc_rise && !ext_edge &&
                        det_cnt_q == `MCG_DET_PERIODS - 2'h1) begin
                        // no edge on the fast source over two watch crystal rises; a high core first waits in SW_STOP
                        src_req_slow_q <= 1'b1;
                        if (core_clk_q) begin
                            sw_state_q <= SW_STOP;
                        end else begin
                            gate_on_q  <= 1'b0;
                            sw_state_q <= SW_GO;
                        end
                    end else if (fast_stb || slow_stb) begin
                        if (slow_stb != src_slow_q) begin
                            src_req_slow_q <= slow_stb;
                            sw_state_q     <= SW_STOP;
                        end
                    end
                end
                SW_STOP: begin
                    if (low_start) begin
                        gate_on_q  <= 1'b0;
                        sw_state_q <= SW_GO;
                    end
                end
                SW_GO: begin
                    // core is already low; restart counting on the new source
                    if (new_edge) begin
                        src_slow_q <= src_req_slow_q;
                        gate_on_q  <= 1'b1;
                        sw_state_q <= SW_RUN;
                    end
                end
                default: begin
                    sw_state_q <= SW_RUN;
                end
            endcase
        end
    end

    // missing-edge detector, armed right after reset release
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            det_active_q <= 1'b1;
            det_cnt_q    <= 2'h0;
        end else if (det_active_q) begin
            if (ext_edge) begin
                det_cnt_q <= 2'h0;
            end else if (wcc_rise) begin
                // only watch crystal edges advance it; no crystal, no firing
                if (det_cnt_q == `MCG_DET_PERIODS - 2'h1)
                    det_active_q <= 1'b0;
                else
                    det_cnt_q <= det_cnt_q + 2'h1;
            end
            if (fast_stb || slow_stb)
                det_active_q <= 1'b0;
        end
    end

    // interval timer on watch crystal periods; firmware uses it to wait settling
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            timer_q <= 32'h0000_0000;
        end else if (wcc_rise) begin
            timer_q <= timer_nxt;
        end
    end

    // sticky wake flag; a compare hit in the cycle of the clear wins
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_q <= 1'b0;
        end else if (wcc_rise && wake_hit) begin
            wake_q <= 1'b1;
        end else if (wake_clear) begin
            wake_q <= 1'b0;
        end
    end

    // software-written registers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_pend_q <= `MCG_DIV_RST;
            ext_khz_q  <= `MCG_EXTKHZ_RST;
            wake_cmp_q <= 32'hFFFF_FFFF;
        end else if (wr_en) begin
            case (paddr)
                `MCG_CTRL_OFF:   div_pend_q <= clamp_div(pwdata);
                `MCG_EXTKHZ_OFF: ext_khz_q  <= pwdata[15:0];
                `MCG_WAKE_OFF:   wake_cmp_q <= pwdata;
                default:         div_pend_q <= div_pend_q;
            endcase
        end
    end

    // apb answer: zero wait states, data prepared in the setup cycle
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_mapped(paddr);
            if (rd_en)
                prdata <= read_word(paddr, div_pend_q, div_q, status_bits, ext_khz_q,
                                    timer_q, wake_cmp_q);
        end
    end

endmodule // mcg_master_clock

// File: sim/mcg_sources.sv
// model of the two clock sources that feed the generator
module mcg_sources #(
    parameter int EXT_HALF = 50,
    parameter int WCC_HALF = 200
) (
    // source enables
    input wire logic ext_en,
    input wire logic wcc_en,
    // source pins
    output logic     external_clock_input,
    output logic     watch_crystal_clock
);
    timeunit 1ns;
    timeprecision 100ps;
    // an oscillator that is switched off stands still
    initial begin
        external_clock_input = 1'b0;
        #3;
        forever #EXT_HALF if (ext_en) external_clock_input = ~external_clock_input;
    end
    initial begin
        watch_crystal_clock = 1'b0;
        #7;
        forever #WCC_HALF if (wcc_en) watch_crystal_clock = ~watch_crystal_clock;
    end
endmodule  // mcg_sources

// File: sim/mcg_master_clock_assertions.sv
// port assertions for the master clock generator
`include "mcg_map.vh"
module mcg_chk (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // clocks and wake
    input wire logic        external_clock_input,
    input wire logic        watch_crystal_clock,
    input wire logic        core_clk_q,
    input wire logic        companion_core_clock_q,
    input wire logic        wake_q
);
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic setup;
    assign setup = psel && !penable;
    chk_ready_after_setup: assert property (setup |=> pready)
        else $error("no ready after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_ready_cause: assert property (pready |-> $past(setup))
        else $error("ready without setup");
    chk_err_unmapped: assert property (setup && !pwrite && paddr > `MCG_WAKE_OFF
        |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
    chk_err_mapped: assert property (setup && paddr == `MCG_CTRL_OFF |=> !pslverr)
        else $error("mapped access refused");
    chk_core_no_runt: assert property ($changed(core_clk_q) |=> $stable(core_clk_q))
        else $error("runt pulse on core clock");
    chk_comp_offset: assert property ($changed(companion_core_clock_q) |-> $stable(core_clk_q))
        else $error("companion moves with core");
    chk_core_needs_edge: assert property (($stable(external_clock_input)
        && $stable(watch_crystal_clock)) [*8] |-> $stable(core_clk_q))
        else $error("core toggles without source edge");
    chk_wake_sticky: assert property (wake_q && !(psel && penable && pwrite
        && paddr == `MCG_STATUS_OFF) |=> wake_q) else $error("wake flag lost");
    cov_core_rise: cover property ($rose(core_clk_q));
    cov_refused: cover property (pslverr);
    cov_wake: cover property ($rose(wake_q));
endmodule  // mcg_chk

bind mcg_master_clock mcg_chk u_chk (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_clock_input(external_clock_input),
    .watch_crystal_clock(watch_crystal_clock), .core_clk_q(core_clk_q),
    .companion_core_clock_q(companion_core_clock_q), .wake_q(wake_q));

// File: sim/tb.sv
// testbench for the master clock generator
`include "mcg_map.vh"
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {logic [31:0] wr; logic [4:0] dv; logic ok;} mcg_row_t;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        ext_en = 1'b1;
    logic        wcc_en = 1'b1;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdata, p;
    logic        pready, pslverr, rerr, xclk, wclk, core, comp, wake;
    int          n_errors = 0;
    int          n_checks = 0;
    mcg_row_t    rows [7] = '{'{32'h2, 5'h02, 1'b0}, '{32'h3, 5'h03, 1'b1},
        '{32'h4, 5'h04, 1'b1}, '{32'h10, 5'h10, 1'b0}, '{32'h0, 5'h02, 1'b0},
        '{32'h11, 5'h10, 1'b0}, '{32'h1, 5'h02, 1'b0}};
    always #12.5 sys_clk = ~sys_clk;
    mcg_master_clock dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_clock_input(xclk), .watch_crystal_clock(wclk),
        .core_clk_q(core), .companion_core_clock_q(comp), .wake_q(wake));
    mcg_sources src (.ext_en(ext_en), .wcc_en(wcc_en), .external_clock_input(xclk),
        .watch_crystal_clock(wclk));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1 && n < 16) begin
            n++;
            @(posedge sys_clk);
        end
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    // cycles between two rising edges of the core clock
    task automatic meas(output logic [31:0] q);
        logic prv;
        int   k;
        k = 0;
        q = 32'h0;
        prv = core;
        repeat (600) if (k < 2) begin
            @(posedge sys_clk);
            if (k == 1) q++;
            if (core === 1'b1 && prv !== 1'b1) k++;
            prv = core;
        end
    endtask
    task automatic settle;
        rdata = 32'h2;
        repeat (100) if (rdata[1] !== 1'b0) apb(1'b0, `MCG_STATUS_OFF, 32'h0);
    endtask
    task automatic reboot(input logic e, input logic w);
        ext_en <= e;
        wcc_en <= w;
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (48) @(posedge sys_clk);
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        conclude;
    end
    initial begin
        reboot(1'b1, 1'b1);
        meas(p);
        chk("reset period", p, 32'h40);
        apb(1'b0, `MCG_CTRL_OFF, 32'h0);
        chk("reset divisor", rdata[12:0], 13'h1010);
        // external source runs 4 system cycles a period
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, `MCG_CTRL_OFF, rows[i].wr);
            meas(p);
            meas(p);
            chk("core period", p, rows[i].dv * 4);
            apb(1'b0, `MCG_CTRL_OFF, 32'h0);
            chk("divisor", rdata[12:0], {rows[i].dv, 3'h0, rows[i].dv});
            apb(1'b0, `MCG_STATUS_OFF, 32'h0);
            chk("rate flag", rdata[3], rows[i].ok);
        end
        apb(1'b1, `MCG_STROBE_OFF, 32'h2);
        settle;
        chk("slow source", rdata[0], 1'b1);
        meas(p);
        meas(p);
        chk("slow period", p, 32'h20);
        // fast source kept running well before switching back, both strobes at once
        apb(1'b1, `MCG_STROBE_OFF, 32'h3);
        settle;
        chk("fast source", rdata[0], 1'b0);
        meas(p);
        meas(p);
        chk("fast period", p, 32'h8);
        apb(1'b0, `MCG_TIMER_OFF, 32'h0);
        apb(1'b1, `MCG_WAKE_OFF, rdata + 32'h2);
        repeat (100) if (wake !== 1'b1) @(posedge sys_clk);
        chk("wake set", wake, 1'b1);
        apb(1'b0, `MCG_STATUS_OFF, 32'h0);
        chk("wake status", rdata[4], 1'b1);
        // let the timer move past the compare value before clearing
        repeat (20) @(posedge sys_clk);
        apb(1'b1, `MCG_STATUS_OFF, 32'h10);
        chk("wake cleared", wake, 1'b0);
        apb(1'b0, 12'h020, 32'h0);
        chk("refused flag", rerr, 1'b1);
        chk("refused data", rdata, 32'h0);
        for (int i = 0; i < 3; i++) begin
            reboot(i == 0, i < 2);
            apb(1'b0, `MCG_STATUS_OFF, 32'h0);
            chk("detected source", rdata[0], i == 1);
        end
        conclude;
    end
endmodule  // tb
